// *** reload_timer_pkg.sv ***
// Constants shared by the reload timer: register offsets, field positions, reset values and mode codes.
package reload_timer_pkg;

   // Register word offsets on the plain register port.
   localparam logic [1:0] ADDR_CONTROL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_RELOAD_VALUE = 2'h1;
   localparam logic [1:0] ADDR_DOWN_COUNTER = 2'h2;

   // Bit positions inside the control and status word.
   localparam int BIT_SW_TRIGGER = 0;
   localparam int BIT_COUNT_ENABLE = 1;
   localparam int BIT_UNDERFLOW = 2;
   localparam int BIT_IRQ_ENABLE = 3;
   localparam int BIT_RELOAD_SELECT = 4;
   localparam int BIT_OUTPUT_LEVEL = 5;
   localparam int BIT_OUTPUT_ENABLE = 6;
   localparam int POS_MODE_LO = 7;
   localparam int POS_MODE_HI = 9;
   localparam int POS_CLOCK_SEL_LO = 10;
   localparam int POS_CLOCK_SEL_HI = 11;

   // Reset values of the stored fields.
   localparam logic [2:0] RESET_MODE = 3'h0;
   localparam logic [1:0] RESET_CLOCK_SEL = 2'h0;
   localparam logic RESET_BIT = 1'b0;

   // Count clock selection: codes 0 to 2 are internal clocks, 3 is event count.
   localparam logic [1:0] CLOCK_SEL_EVENT = 2'h3;

   // Operation mode codes in internal clock mode.
   localparam logic [2:0] MODE_SOFTWARE = 3'h0;
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Control state of the timer.
   typedef enum logic [1:0] {
      TIMER_STOP,
      TIMER_WAIT,
      TIMER_LOAD,
      TIMER_RUN
   } timer_state_t;

endpackage : reload_timer_pkg

// *** reload_timer.sv ***
// Start, count and underflow control of a down-counting reload timer with its register port.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns

module reload_timer #(
   parameter int WIDTH = 16
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Register port.
   input wire logic [1:0] reg_addr,
   input wire logic [WIDTH-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [WIDTH-1:0] reg_rdata,
   // Internal count clock tick from the prescaler, one cycle per count.
   input wire logic count_clock_tick,
   // Trigger, gate or event pin.
   input wire logic event_trigger_input,
   // Timer output pin and its drive enable.
   output logic timer_output_pin,
   output logic timer_output_enable,
   // Interrupt request and service acknowledge.
   output logic underflow_irq,
   input wire logic service_clear
);

   // The control word needs twelve bits, so narrower counters are refused at elaboration.
   if (WIDTH < 12)
   begin : g_width_check
      $error("reload_timer: WIDTH must be at least 12");
   end

   localparam logic [WIDTH-1:0] ZERO = '0;
   localparam logic [WIDTH-1:0] ALL_ONES = '1;

   // Stored control fields.
   logic count_enable_bit;
   logic underflow_flag;
   logic underflow_irq_enable;
   logic reload_select;
   logic output_level_select;
   logic output_enable_bit;
   logic [2:0] operation_mode_select;
   logic [1:0] count_clock_select;
   logic [WIDTH-1:0] reload_value_register;
   logic [WIDTH-1:0] down_counter;
   logic toggle_level;
   reload_timer_pkg::timer_state_t state;
   logic input_last;
   logic input_prev;

   // Next values.
   logic next_count_enable_bit;
   logic next_underflow_flag;
   logic next_underflow_irq_enable;
   logic next_reload_select;
   logic next_output_level_select;
   logic next_output_enable_bit;
   logic [2:0] next_operation_mode_select;
   logic [1:0] next_count_clock_select;
   logic [WIDTH-1:0] next_reload_value_register;
   logic [WIDTH-1:0] next_down_counter;
   logic next_toggle_level;
   reload_timer_pkg::timer_state_t next_state;
   logic [WIDTH-1:0] next_reg_rdata;

   // Decoded conditions.
   logic write_control;
   logic sw_trigger;
   logic event_mode;
   logic gate_mode;
   logic ext_trigger_mode;
   logic [1:0] edge_select;
   logic rise_seen;
   logic fall_seen;
   logic edge_seen;
   logic ext_trigger;
   logic gate_open;
   logic count_step;
   logic underflow;
   logic control_enable;

   // Two-stage input history; the pin is synchronous, so the first stage is directly usable.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         input_last <= 1'b0;
         input_prev <= 1'b0;
      end
      else
      begin
         input_last <= event_trigger_input;
         input_prev <= input_last;
      end
   end

   // Edge and mode decoding.
   always_comb
   begin
      write_control = reg_write && (reg_addr == reload_timer_pkg::ADDR_CONTROL_STATUS);
      control_enable = write_control ? reg_wdata[reload_timer_pkg::BIT_COUNT_ENABLE] : count_enable_bit;
      sw_trigger = write_control && reg_wdata[reload_timer_pkg::BIT_SW_TRIGGER] && control_enable;
      event_mode = (count_clock_select == reload_timer_pkg::CLOCK_SEL_EVENT);
      gate_mode = !event_mode && operation_mode_select[2];
      ext_trigger_mode = !event_mode && !operation_mode_select[2]
         && (operation_mode_select != reload_timer_pkg::MODE_SOFTWARE);
      edge_select = operation_mode_select[1:0];
      rise_seen = input_last && !input_prev;
      fall_seen = !input_last && input_prev;
      // Edges are taken from registered history, which gives the documented two-cycle trigger latency.
      edge_seen = ((edge_select == reload_timer_pkg::EDGE_RISING) && rise_seen)
         || ((edge_select == reload_timer_pkg::EDGE_FALLING) && fall_seen)
         || ((edge_select == reload_timer_pkg::EDGE_BOTH) && (rise_seen || fall_seen));
      ext_trigger = ext_trigger_mode && count_enable_bit && edge_seen;
      gate_open = (input_last == operation_mode_select[0]);
      if (event_mode)
      begin
         count_step = edge_seen;
      end
      else if (gate_mode)
      begin
         count_step = count_clock_tick && gate_open;
      end
      else
      begin
         count_step = count_clock_tick;
      end
      underflow = (state == reload_timer_pkg::TIMER_RUN) && count_step && (down_counter == ZERO);
   end

   // Next values of the control register, counter and state.
   always_comb
   begin
      next_count_enable_bit = count_enable_bit;
      next_underflow_irq_enable = underflow_irq_enable;
      next_reload_select = reload_select;
      next_output_level_select = output_level_select;
      next_output_enable_bit = output_enable_bit;
      next_operation_mode_select = operation_mode_select;
      next_count_clock_select = count_clock_select;
      next_reload_value_register = reload_value_register;
      next_down_counter = down_counter;
      next_toggle_level = toggle_level;
      next_state = state;
      next_underflow_flag = underflow_flag;

      // Software writes of the stored fields; mode and clock changes rely on software stopping first.
      if (write_control)
      begin
         next_count_enable_bit = reg_wdata[reload_timer_pkg::BIT_COUNT_ENABLE];
         next_underflow_irq_enable = reg_wdata[reload_timer_pkg::BIT_IRQ_ENABLE];
         next_reload_select = reg_wdata[reload_timer_pkg::BIT_RELOAD_SELECT];
         next_output_level_select = reg_wdata[reload_timer_pkg::BIT_OUTPUT_LEVEL];
         next_output_enable_bit = reg_wdata[reload_timer_pkg::BIT_OUTPUT_ENABLE];
         next_operation_mode_select = reg_wdata[reload_timer_pkg::POS_MODE_HI:reload_timer_pkg::POS_MODE_LO];
         next_count_clock_select = reg_wdata[reload_timer_pkg::POS_CLOCK_SEL_HI:reload_timer_pkg::POS_CLOCK_SEL_LO];
         // Writing zero clears the flag, writing one leaves it.
         if (!reg_wdata[reload_timer_pkg::BIT_UNDERFLOW])
         begin
            next_underflow_flag = 1'b0;
         end
      end
      if (service_clear)
      begin
         next_underflow_flag = 1'b0;
      end
      if (reg_write && (reg_addr == reload_timer_pkg::ADDR_RELOAD_VALUE))
      begin
         next_reload_value_register = reg_wdata;
      end

      case (state)
         reload_timer_pkg::TIMER_STOP:
         begin
            if (sw_trigger)
            begin
               next_state = reload_timer_pkg::TIMER_LOAD;
            end
            else if (control_enable)
            begin
               next_state = reload_timer_pkg::TIMER_WAIT;
            end
         end
         reload_timer_pkg::TIMER_WAIT, reload_timer_pkg::TIMER_RUN:
         begin
            if (state == reload_timer_pkg::TIMER_RUN && count_step)
            begin
               if (underflow && reload_select)
               begin
                  next_down_counter = reload_value_register;
                  next_toggle_level = !toggle_level;
               end
               else if (underflow)
               begin
                  next_down_counter = ALL_ONES;
                  next_state = reload_timer_pkg::TIMER_WAIT;
               end
               else
               begin
                  next_down_counter = down_counter - 1'b1;
               end
            end
            if (ext_trigger)
            begin
               // The edge is already one cycle old in the registered history, so the load lands in this cycle.
               next_down_counter = reload_value_register;
               next_toggle_level = output_level_select;
               next_state = reload_timer_pkg::TIMER_RUN;
            end
            else if (sw_trigger)
            begin
               next_state = reload_timer_pkg::TIMER_LOAD;
            end
         end
         reload_timer_pkg::TIMER_LOAD:
         begin
            // One machine cycle after the trigger write the reload value enters the counter.
            next_down_counter = reload_value_register;
            next_toggle_level = output_level_select;
            next_state = reload_timer_pkg::TIMER_RUN;
         end
         default:
         begin
            next_state = reload_timer_pkg::TIMER_STOP;
         end
      endcase

      // Clearing the enable forces the stop state, whatever else the state logic chose in this cycle.
      if (write_control && !reg_wdata[reload_timer_pkg::BIT_COUNT_ENABLE])
      begin
         next_state = reload_timer_pkg::TIMER_STOP;
      end

      // A new underflow wins over any clear in the same cycle.
      if (underflow)
      begin
         next_underflow_flag = 1'b1;
      end
   end

   // Read data for the cycle after a read strobe; the counter is returned as one word.
   always_comb
   begin
      next_reg_rdata = ZERO;
      if (reg_read)
      begin
         case (reg_addr)
            reload_timer_pkg::ADDR_CONTROL_STATUS:
            begin
               next_reg_rdata[reload_timer_pkg::BIT_COUNT_ENABLE] = count_enable_bit;
               next_reg_rdata[reload_timer_pkg::BIT_UNDERFLOW] = underflow_flag;
               next_reg_rdata[reload_timer_pkg::BIT_IRQ_ENABLE] = underflow_irq_enable;
               next_reg_rdata[reload_timer_pkg::BIT_RELOAD_SELECT] = reload_select;
               next_reg_rdata[reload_timer_pkg::BIT_OUTPUT_LEVEL] = output_level_select;
               next_reg_rdata[reload_timer_pkg::BIT_OUTPUT_ENABLE] = output_enable_bit;
               next_reg_rdata[reload_timer_pkg::POS_MODE_HI:reload_timer_pkg::POS_MODE_LO] = operation_mode_select;
               next_reg_rdata[reload_timer_pkg::POS_CLOCK_SEL_HI:reload_timer_pkg::POS_CLOCK_SEL_LO] =
                  count_clock_select;
            end
            reload_timer_pkg::ADDR_RELOAD_VALUE:
            begin
               next_reg_rdata = reload_value_register;
            end
            reload_timer_pkg::ADDR_DOWN_COUNTER:
            begin
               next_reg_rdata = down_counter;
            end
            default:
            begin
               next_reg_rdata = ZERO;
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         count_enable_bit <= reload_timer_pkg::RESET_BIT;
         underflow_flag <= reload_timer_pkg::RESET_BIT;
         underflow_irq_enable <= reload_timer_pkg::RESET_BIT;
         reload_select <= reload_timer_pkg::RESET_BIT;
         output_level_select <= reload_timer_pkg::RESET_BIT;
         output_enable_bit <= reload_timer_pkg::RESET_BIT;
         operation_mode_select <= reload_timer_pkg::RESET_MODE;
         count_clock_select <= reload_timer_pkg::RESET_CLOCK_SEL;
         reload_value_register <= '0;
         down_counter <= '0;
         toggle_level <= reload_timer_pkg::RESET_BIT;
         state <= reload_timer_pkg::TIMER_STOP;
         reg_rdata <= '0;
         timer_output_pin <= 1'b0;
         timer_output_enable <= 1'b0;
         underflow_irq <= 1'b0;
      end
      else
      begin
         count_enable_bit <= next_count_enable_bit;
         underflow_flag <= next_underflow_flag;
         underflow_irq_enable <= next_underflow_irq_enable;
         reload_select <= next_reload_select;
         output_level_select <= next_output_level_select;
         output_enable_bit <= next_output_enable_bit;
         operation_mode_select <= next_operation_mode_select;
         count_clock_select <= next_count_clock_select;
         reload_value_register <= next_reload_value_register;
         down_counter <= next_down_counter;
         toggle_level <= next_toggle_level;
         state <= next_state;
         reg_rdata <= next_reg_rdata;
         // One-shot shows the selected level only while running; reload shows the toggle.
         if (next_reload_select)
         begin
            timer_output_pin <= next_toggle_level;
         end
         else
         begin
            timer_output_pin <= (next_state == reload_timer_pkg::TIMER_RUN) ?
               next_output_level_select : !next_output_level_select;
         end
         timer_output_enable <= next_output_enable_bit && next_count_enable_bit;
         underflow_irq <= next_underflow_flag && next_underflow_irq_enable;
      end
   end

endmodule : reload_timer

// *** reload_timer_properties.sv ***
// Port-level checks of the reload timer control, output and interrupt behaviour.
`timescale 1ns/1ns
module reload_timer_properties #(
   parameter int WIDTH = 16
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Register port.
   input wire logic [1:0] reg_addr,
   input wire logic [WIDTH-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [WIDTH-1:0] reg_rdata,
   // Pins and service side.
   input wire logic count_clock_tick,
   input wire logic event_trigger_input,
   input wire logic timer_output_pin,
   input wire logic timer_output_enable,
   input wire logic underflow_irq,
   input wire logic service_clear
);
   logic wr_ctl;
   logic oe_q;
   logic level_q;
   logic reload_q;
   // Most checked outputs are caused by a control word write.
   assign wr_ctl = reg_write && reg_addr == reload_timer_pkg::ADDR_CONTROL_STATUS;
   // Last written output fields, so no check needs a deep history.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         oe_q <= 1'b0;
         level_q <= 1'b0;
         reload_q <= 1'b0;
      end
      else if (wr_ctl)
      begin
         oe_q <= reg_wdata[6] & reg_wdata[1];
         level_q <= reg_wdata[5];
         reload_q <= reg_wdata[4];
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence start_wr;
      wr_ctl && reg_wdata[1] && reg_wdata[0];
   endsequence
   sequence stop_wr;
      wr_ctl && !reg_wdata[1];
   endsequence
   AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 16'h0)
      else $error("read data not zero outside a read answer");
   AST_UNMAPPED_READ: assert property (reg_read && reg_addr == 2'h3 |=> reg_rdata == 16'h0)
      else $error("unmapped address read not zero");
   AST_TRIGGER_READS_ZERO: assert property (reg_read && !reg_addr |=> !reg_rdata[0])
      else $error("trigger bit read back as one");
   AST_START_LEVEL: assert property (start_wr ##1 !wr_ctl |=> timer_output_pin == level_q)
      else $error("output pin not at selected level after start");
   AST_STOP_LEVEL: assert property (stop_wr ##1 !wr_ctl |=> reload_q || timer_output_pin != level_q)
      else $error("stopped one-shot output not at inverse level");
   AST_OUT_ENABLE: assert property (wr_ctl ##1 !wr_ctl |=> timer_output_enable == oe_q)
      else $error("output enable does not follow control bits");
   AST_IRQ_MASKED: assert property (wr_ctl && !reg_wdata[3] ##1 !wr_ctl |=> !underflow_irq)
      else $error("interrupt request while disabled");
   AST_FLAG_CLEAR: assert property (stop_wr ##1 !(wr_ctl && reg_wdata[1]) ##1 stop_wr ##0 !reg_wdata[2]
      |=> ##1 !underflow_irq)
      else $error("interrupt request stays after flag clear");
endmodule : reload_timer_properties

// *** event_source.sv ***
// Far-side source of the trigger, gate and event pin.
`timescale 1ns/1ns
module event_source (
   // Clock.
   input wire logic mclk,
   // Driven pin.
   output logic event_trigger_input
);
   // Idles low; callers set the idle level they need before each use.
   initial event_trigger_input = 1'b0;
   // Every level stands five cycles, above both the pulse and the event minimums.
   task automatic hold(input logic level);
      @(posedge mclk);
      event_trigger_input <= level;
      repeat (4) @(posedge mclk);
   endtask : hold
   // One full pulse away from the idle level and back.
   task automatic pulse(input logic level);
      hold(level);
      hold(!level);
   endtask : pulse
endmodule : event_source

// *** reload_timer_tb.sv ***
// Self-checking testbench of the reload timer start, count and underflow control.
`timescale 1ns/1ns
module reload_timer_tb;
   localparam logic [1:0] CTL = reload_timer_pkg::ADDR_CONTROL_STATUS;
   localparam logic [1:0] RLV = reload_timer_pkg::ADDR_RELOAD_VALUE;
   localparam logic [1:0] CNT = reload_timer_pkg::ADDR_DOWN_COUNTER;
   localparam logic [15:0] SW_TRIG = 16'h0001;
   localparam logic [15:0] EN = 16'h0002;
   localparam logic [15:0] IRQ_EN = 16'h0008;
   localparam logic [15:0] RLD = 16'h0010;
   localparam logic [15:0] LEVEL = 16'h0020;
   localparam logic [15:0] OUT_EN = 16'h0040;
   logic mclk;
   logic rst;
   logic [1:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [15:0] reg_rdata;
   logic count_clock_tick;
   logic event_trigger_input;
   logic timer_output_pin;
   logic timer_output_enable;
   logic underflow_irq;
   logic service_clear;
   int n_mismatch;
   int cmp_count;
   reload_timer dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .count_clock_tick(count_clock_tick),
      .event_trigger_input(event_trigger_input), .timer_output_pin(timer_output_pin),
      .timer_output_enable(timer_output_enable), .underflow_irq(underflow_irq), .service_clear(service_clear));
   event_source src (.mclk(mclk), .event_trigger_input(event_trigger_input));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Register cycles change only after an edge and drop the strobe at the sampling edge.
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [1:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rdc
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         count_clock_tick <= 1'b1;
         @(posedge mclk);
         count_clock_tick <= 1'b0;
      end
   endtask : tick
   // Two disabling writes: the second also clears the flag once nothing runs.
   task automatic stop;
      wr(CTL, 16'h0000);
      wr(CTL, 16'h0000);
   endtask : stop
   task automatic t_one_shot;
      rdc(CTL, 16'h0000);
      wr(2'h3, 16'hffff);
      rdc(2'h3, 16'h0000);
      wr(RLV, 16'h0003);
      wr(CTL, EN | SW_TRIG | IRQ_EN);
      rdc(CNT, 16'h0003);
      chk(16'(timer_output_pin), 16'h0000);
      tick(2);
      rdc(CNT, 16'h0001);
      tick(2);
      rdc(CNT, 16'hffff);
      rdc(CTL, EN | IRQ_EN | 16'h0004);
      chk(16'(underflow_irq), 16'h0001);
      chk(16'(timer_output_pin), 16'h0001);
      tick(2);
      rdc(CNT, 16'hffff);
      // A new trigger restarts the one-shot; writing the flag bit as one keeps the request.
      wr(CTL, EN | SW_TRIG | IRQ_EN | 16'h0004);
      rdc(CNT, 16'h0003);
      chk(16'(underflow_irq), 16'h0001);
      stop();
      @(posedge mclk);
      #1;
      chk(16'(underflow_irq), 16'h0000);
   endtask : t_one_shot
   task automatic t_reload;
      wr(RLV, 16'h0001);
      wr(CTL, EN | SW_TRIG | RLD | LEVEL | OUT_EN);
      rdc(CNT, 16'h0001);
      chk(16'(timer_output_pin), 16'h0001);
      chk(16'(timer_output_enable), 16'h0001);
      tick(2);
      rdc(CNT, 16'h0001);
      chk(16'(timer_output_pin), 16'h0000);
      tick(2);
      rdc(CNT, 16'h0001);
      chk(16'(timer_output_pin), 16'h0001);
      @(posedge mclk);
      service_clear <= 1'b1;
      @(posedge mclk);
      service_clear <= 1'b0;
      rdc(CTL, EN | RLD | LEVEL | OUT_EN);
      stop();
      chk(16'(timer_output_enable), 16'h0000);
   endtask : t_reload
   // Each edge mode, idling at the level from which its edge leaves.
   task automatic t_ext;
      logic lvl;
      for (int m = 1; m < 4; m++)
      begin
         lvl = (m == 2);
         src.hold(lvl);
         wr(RLV, 16'h0010 | 16'(m));
         wr(CTL, EN | (16'(m) << 7));
         src.pulse(!lvl);
         rdc(CNT, 16'h0010 | 16'(m));
         stop();
      end
      src.hold(1'b0);
   endtask : t_ext
   // Both gate levels: closed first, then open.
   task automatic t_gate;
      for (int g = 0; g < 2; g++)
      begin
         src.hold(g == 0);
         wr(RLV, 16'h0004);
         wr(CTL, EN | SW_TRIG | 16'h0200 | (16'(g) << 7));
         rdc(CNT, 16'h0004);
         tick(2);
         rdc(CNT, 16'h0004);
         src.hold(g == 1);
         tick(2);
         rdc(CNT, 16'h0002);
         stop();
      end
      src.hold(1'b0);
   endtask : t_gate
   // Rising, falling and both edges: two pulses give two, two and four steps.
   task automatic t_event;
      for (int e = 1; e < 4; e++)
      begin
         wr(RLV, 16'h0005);
         wr(CTL, EN | SW_TRIG | 16'h0c00 | (16'(e) << 7));
         rdc(CNT, 16'h0005);
         tick(2);
         rdc(CNT, 16'h0005);
         src.pulse(1'b1);
         src.pulse(1'b1);
         rdc(CNT, (e == 3) ? 16'h0001 : 16'h0003);
         stop();
      end
   endtask : t_event
   task automatic summarize;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // Free-running machine clock of 50 ns.
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Main sequence after twelve cycles of reset.
   initial
   begin
      rst = 1'b1;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      count_clock_tick = 1'b0;
      service_clear = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_one_shot();
      t_reload();
      t_ext();
      t_gate();
      t_event();
      summarize();
   end
   // The tests need well under a thousand cycles; a hang is cut at five thousand.
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      summarize();
   end
endmodule : reload_timer_tb
bind reload_timer reload_timer_properties #(.WIDTH(WIDTH)) props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .count_clock_tick(count_clock_tick), .event_trigger_input(event_trigger_input),
   .timer_output_pin(timer_output_pin), .timer_output_enable(timer_output_enable),
   .underflow_irq(underflow_irq), .service_clear(service_clear));
